// >>> design/flash_cmd_pkg.sv
// Constants for the host-side flash command sequencer
package flash_cmd_pkg;
  localparam int          ADDR_W        = 19;           // Word address width
  localparam int          DATA_W        = 16;           // Data bus width
  localparam int          ADDR_LOW_W    = 11;           // Command address lines
  localparam logic [10:0] UNLOCK_ADDR1  = 11'h555;      // First unlock address
  localparam logic [10:0] UNLOCK_ADDR2  = 11'h2aa;      // Second unlock address
  localparam logic [10:0] CFI_ONE_ADDR  = 11'h055;      // One-write query address
  localparam logic [7:0]  UNLOCK_DATA1  = 8'haa;        // First unlock data
  localparam logic [7:0]  UNLOCK_DATA2  = 8'h55;        // Second unlock data
  localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;        // Word program
  localparam logic [7:0]  CMD_ERASE     = 8'h80;        // Erase setup
  localparam logic [7:0]  CMD_SECTOR    = 8'h50;        // Sector erase
  localparam logic [7:0]  CMD_BLOCK     = 8'h30;        // Block erase
  localparam logic [7:0]  CMD_CHIP      = 8'h10;        // Chip erase
  localparam logic [7:0]  CMD_CFI       = 8'h98;        // Query entry
  localparam logic [7:0]  CMD_IDENT     = 8'h90;        // Identification entry
  localparam logic [7:0]  CMD_EXIT      = 8'hf0;        // Mode exit
  localparam logic [7:0]  CMD_SEC_PROG  = 8'ha5;        // Security word program
  localparam logic [7:0]  CMD_SEC_LOCK  = 8'h85;        // Security lock-out
  localparam logic [7:0]  CMD_SEC_READ  = 8'h88;        // Security read entry
  localparam logic [15:0] LOCK_DATA     = 16'h0000;     // Lock-out fourth word
  localparam logic [7:0]  UPPER_FILL    = 8'h00;        // Valid level for upper_data_byte
  localparam int          SECURITY_ID_AREA_WORDS  = 136;          // Security space size
  localparam logic [3:0]  WAIT_CYCLES   = 4'h2;         // Strobe and gap timer reload; each state lasts this plus one clock
  // Host operation codes
  localparam logic [3:0]  OP_PROGRAM    = 4'h0;
  localparam logic [3:0]  OP_SECTOR     = 4'h1;
  localparam logic [3:0]  OP_BLOCK      = 4'h2;
  localparam logic [3:0]  OP_CHIP       = 4'h3;
  localparam logic [3:0]  OP_IDENT      = 4'h4;
  localparam logic [3:0]  OP_CFI        = 4'h5;
  localparam logic [3:0]  OP_CFI_ONE    = 4'h6;
  localparam logic [3:0]  OP_SEC_READ   = 4'h7;
  localparam logic [3:0]  OP_SEC_PROG   = 4'h8;
  localparam logic [3:0]  OP_SEC_LOCK   = 4'h9;
  localparam logic [3:0]  OP_EXIT_LONG  = 4'ha;
  localparam logic [3:0]  OP_EXIT_SHORT = 4'hb;
  localparam logic [3:0]  OP_READ       = 4'hc;
endpackage : flash_cmd_pkg

// >>> design/flash_command_sequencer.sv
// Host controller that issues flash command sequences over the parallel pins
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer
  import flash_cmd_pkg::*;
#(
  parameter logic [15:0] CFI_ONE_DATA = 16'h0098  // Table value; prose disagrees
) (
  input  wire logic              mclk_in,        // 100 MHz clock
  input  wire logic              rst_n_in,       // Synchronous reset, active low
  input  wire logic              req_valid_in,   // Operation request
  input  wire logic [3:0]        req_op_in,      // Operation code
  input  wire logic [ADDR_W-1:0] req_addr_in,    // Target or read address
  input  wire logic [DATA_W-1:0] req_data_in,    // Program data
  input  wire logic              flash_busy_in,  // Device busy (ready/busy pin low)
  input  wire logic [DATA_W-1:0] dq_in,          // Data pins sampled
  output logic                   req_ready_out,  // Idle, request accepted
  output logic                   done_out,       // One-cycle completion pulse
  output logic [DATA_W-1:0]      rd_data_out,    // Last read word
  output logic                   rst_n_out,      // Device hardware reset
  output logic                   ce_n_out,       // Chip select
  output logic                   oe_n_out,       // Output enable
  output logic                   we_n_out,       // Write strobe
  output logic [ADDR_W-1:0]      addr_out,       // Address pins
  output logic [DATA_W-1:0]      dq_out,         // Data pins drive value
  output logic                   dq_oe_n_out     // Low while host drives data
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,  // Waiting for request
    ST_WRITE = 4'b0010,  // Write strobe low
    ST_READ  = 4'b0100,  // Read strobe low
    ST_GAP   = 4'b1000   // Strobes released between cycles
  } state_e;

  state_e               state;     // Bus cycle state
  logic [3:0]           op;        // Latched operation
  logic [2:0]           step;      // Write index inside sequence
  logic [2:0]           last_step; // Final write index
  logic [3:0]           wait_cnt;  // Strobe timer
  logic [ADDR_W-1:0]    taddr;     // Latched target address
  logic [DATA_W-1:0]    tdata;     // Latched data

  // Number of writes for each operation except read, minus one
  function automatic logic [2:0] seq_len(input logic [3:0] o);
    case (o)
      OP_PROGRAM, OP_SEC_PROG, OP_SEC_LOCK:  seq_len = 3'd3;
      OP_SECTOR, OP_BLOCK, OP_CHIP:          seq_len = 3'd5;
      OP_CFI_ONE, OP_EXIT_SHORT, OP_READ:    seq_len = 3'd0;
      default:                               seq_len = 3'd2;
    endcase
  endfunction : seq_len

  // Command byte of the third write
  function automatic logic [7:0] third_cmd(input logic [3:0] o);
    case (o)
      OP_PROGRAM:  third_cmd = CMD_PROGRAM;
      OP_IDENT:    third_cmd = CMD_IDENT;
      OP_CFI:      third_cmd = CMD_CFI;
      OP_SEC_READ: third_cmd = CMD_SEC_READ;
      OP_SEC_PROG: third_cmd = CMD_SEC_PROG;
      OP_SEC_LOCK: third_cmd = CMD_SEC_LOCK;
      OP_EXIT_LONG: third_cmd = CMD_EXIT;
      default:     third_cmd = CMD_ERASE;
    endcase
  endfunction : third_cmd

  // Address and data for one write of the sequence
  logic [ADDR_W-1:0] w_addr;  // Address of current write
  logic [DATA_W-1:0] w_data;  // Data of current write
  always_comb begin
    w_addr = '0;
    w_data = {UPPER_FILL, UNLOCK_DATA1};
    case (step)
      3'd0, 3'd3: begin
        w_addr = {{(ADDR_W-ADDR_LOW_W){1'b0}}, UNLOCK_ADDR1};
        w_data = {UPPER_FILL, UNLOCK_DATA1};
      end
      3'd1, 3'd4: begin
        w_addr = {{(ADDR_W-ADDR_LOW_W){1'b0}}, UNLOCK_ADDR2};
        w_data = {UPPER_FILL, UNLOCK_DATA2};
      end
      3'd2: begin
        w_addr = {{(ADDR_W-ADDR_LOW_W){1'b0}}, UNLOCK_ADDR1};
        w_data = {UPPER_FILL, third_cmd(op)};
      end
      default: begin
        w_addr = '0;
        w_data = '0;
      end
    endcase
    // Single-write commands and final writes
    if (op == OP_CFI_ONE) begin
      w_addr = {{(ADDR_W-ADDR_LOW_W){1'b0}}, CFI_ONE_ADDR};
      w_data = CFI_ONE_DATA;
    end else if (op == OP_EXIT_SHORT) begin
      w_addr = taddr;
      w_data = {UPPER_FILL, CMD_EXIT};
    end else if (step == 3'd3 && (op == OP_PROGRAM || op == OP_SEC_PROG)) begin
      w_addr = taddr;
      w_data = tdata;
    end else if (step == 3'd3 && op == OP_SEC_LOCK) begin
      w_addr = taddr;
      w_data = LOCK_DATA;
    end else if (step == 3'd5) begin
      // erase begins on this strobe rise
      w_addr = (op == OP_CHIP) ? {{(ADDR_W-ADDR_LOW_W){1'b0}}, UNLOCK_ADDR1} : taddr;
      w_data = {UPPER_FILL, (op == OP_SECTOR) ? CMD_SECTOR :
                            (op == OP_BLOCK) ? CMD_BLOCK : CMD_CHIP};
    end
  end

  // Hold off new work while the device reports busy
  // no exit during busy
  // completion seen from busy pin, not polling
  assign req_ready_out = (state == ST_IDLE) && !flash_busy_in;
  assign rst_n_out     = rst_n_in;  // reset passes to device

  // Bus cycle sequencer
  // reset returns tracker idle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state     <= ST_IDLE;
      op        <= OP_READ;
      step      <= 3'd0;
      last_step <= 3'd0;
      wait_cnt  <= 4'h0;
      taddr     <= '0;
      tdata     <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_valid_in && req_ready_out) begin
            op        <= req_op_in;
            taddr     <= req_addr_in;
            tdata     <= req_data_in;
            step      <= 3'd0;
            last_step <= seq_len(req_op_in);
            wait_cnt  <= WAIT_CYCLES;
            state     <= (req_op_in == OP_READ) ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE, ST_READ: begin
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else begin
            wait_cnt <= WAIT_CYCLES;
            state    <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (op != OP_READ && step != last_step) begin
            step     <= step + 3'd1;
            wait_cnt <= WAIT_CYCLES;
            state    <= ST_WRITE;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pin drivers registered from state
  // output enable high whenever writing
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ce_n_out    <= 1'b1;
      oe_n_out    <= 1'b1;
      we_n_out    <= 1'b1;
      addr_out    <= '0;
      dq_out      <= '0;
      dq_oe_n_out <= 1'b1;
    end else begin
      ce_n_out    <= !(state == ST_WRITE || state == ST_READ);
      oe_n_out    <= !(state == ST_READ);
      we_n_out    <= !(state == ST_WRITE);
      addr_out    <= (state == ST_READ) ? taddr : w_addr;
      dq_out      <= w_data;
      // Keep data driven through the gap so it outlasts the strobe rise
      dq_oe_n_out <= !(state == ST_WRITE || (state == ST_GAP && op != OP_READ));
    end
  end

  // Capture read data and flag completion
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
      done_out    <= 1'b0;
    end else begin
      done_out <= (state == ST_GAP) && (wait_cnt == 4'h0) &&
                  (op == OP_READ || step == last_step);
      // Last ST_READ cycle: the read word has had two of the three registered strobe-low cycles to settle
      if (state == ST_READ && wait_cnt == 4'h0) begin
        rd_data_out <= dq_in;
      end
    end
  end

  // write strobe never with output enable
  strobe_excl_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !(!we_n_out && !oe_n_out)) else $error("write and read strobes overlap");

  read_alone_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_READ) |-> op == OP_READ) else $error("read inside sequence");

  sequence unlock_first_s;
    state == ST_WRITE && step == 3'd0 && seq_len(op) != 3'd0;
  endsequence
  // first write is AAH at 555H
  unlock_word_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    unlock_first_s |=> (addr_out[ADDR_LOW_W-1:0] == UNLOCK_ADDR1 && dq_out[7:0] == UNLOCK_DATA1))
    else $error("bad first unlock write");

  // upper byte held at valid fill in prefix
  upper_fill_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_WRITE && step < 3'd3 && op != OP_CFI_ONE) |=> dq_out[15:8] == UPPER_FILL)
    else $error("upper byte not driven to fill");

  // chip erase sixth write at 555H with 10H
  chip_erase_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_WRITE && step == 3'd5 && op == OP_CHIP) |=>
      (dq_out[7:0] == CMD_CHIP && addr_out[ADDR_LOW_W-1:0] == UNLOCK_ADDR1))
    else $error("bad chip erase write");

  busy_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (flash_busy_in && state == ST_IDLE) |=> state == ST_IDLE) else $error("request taken while busy");

  cfi_one_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_WRITE && op == OP_CFI_ONE) |=> addr_out[ADDR_LOW_W-1:0] == CFI_ONE_ADDR)
    else $error("bad one-write query address");

  lock_word_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_WRITE && step == 3'd3 && op == OP_SEC_LOCK) |=> dq_out == LOCK_DATA)
    else $error("lock word not zero");

  reset_idle_a: assert property (@(posedge mclk_in)
    !rst_n_in |=> (ce_n_out && we_n_out && oe_n_out)) else $error("strobes active after reset");

  // data pins driven under every write strobe
  dq_drive_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !we_n_out |-> !dq_oe_n_out) else $error("write strobe without data drive");

  // Third write of any unlock-prefixed sequence
  sequence third_write_s;
    state == ST_WRITE && step == 3'd2;
  endsequence
  // identification entry is 90H at 555H
  ident_entry_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    third_write_s ##0 (op == OP_IDENT) |=>
      (addr_out[ADDR_LOW_W-1:0] == UNLOCK_ADDR1 && dq_out[7:0] == CMD_IDENT))
    else $error("bad identification entry write");

  // security read entry is 88H at 555H
  sec_entry_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    third_write_s ##0 (op == OP_SEC_READ) |=>
      (addr_out[ADDR_LOW_W-1:0] == UNLOCK_ADDR1 && dq_out[7:0] == CMD_SEC_READ))
    else $error("bad security read entry write");

  exit_short_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_WRITE && op == OP_EXIT_SHORT) |=> dq_out[7:0] == CMD_EXIT)
    else $error("bad single exit write");
endmodule : flash_command_sequencer
`default_nettype wire

// >>> sim/flash_device_model.sv
// Behavioural parallel flash that answers the sequencer's pins
`timescale 1ns/1ns
`default_nettype none
module flash_device_model #(
  parameter logic [15:0] MAKER = 16'h00c3,  // Arbitrary maker code
  parameter logic [15:0] PART  = 16'h7e21   // Arbitrary part code
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [18:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic             busy_out,
  output logic [15:0]      dq_out
);
  logic [15:0] mem [int];          // Array words, absent reads as erased
  logic [15:0] sec [int];          // Security words
  int          step;               // Sequence tracker step
  int          mode;               // 0 array, 1 identity, 2 query, 3 security
  int          busy_cnt;           // Remaining busy cycles
  logic        locked = 1'b0;      // User security segment locked
  logic        pwe, pce, poe;      // Strobes one edge earlier
  logic [7:0]  cmd;                // Third write command byte
  wire  [7:0]  d = dq_in[7:0];     // Upper byte ignored
  wire  [10:0] a = addr_in[10:0];  // Upper address ignored
  assign busy_out = busy_cnt != 0;
  // fixed identity words; no pull on the bus, so a released bus shows inverted data
  always @(ce_n_in or oe_n_in or addr_in or mode) begin
    if (!ce_n_in && !oe_n_in)
      dq_out = mode == 1 ? (addr_in == 0 ? MAKER : PART) : mode == 2 ? 16'hc000 | addr_in[7:0] :
               mode == 3 ? (sec.exists(addr_in) ? sec[addr_in] : 16'hffff) :
               (mem.exists(addr_in) ? mem[addr_in] : 16'hffff);
    else
      dq_out = ~dq_out;
  end
  // Write decode at each strobe rise
  always @(posedge mclk_in) begin
    pwe <= we_n_in;
    pce <= ce_n_in;
    poe <= oe_n_in;
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (!rst_n_in) begin
      step = 0;
      mode = 0;
      busy_cnt <= 0;
    end
    else if (poe && !oe_n_in && !ce_n_in) step = 0;
    // ignore while busy or output enabled
    else if (!pwe && !pce && we_n_in && oe_n_in && busy_cnt == 0) begin
      case (step)
        0: begin
          if (a == 11'h555 && d == 8'haa) step = 1;
          else if (d == 8'hf0) mode = 0;
          else if (a == 11'h055 && d == 8'h98) mode = 2;
        end
        1, 5: step = (a == 11'h2aa && d == 8'h55) ? step + 1 : 0;
        4: step = (a == 11'h555 && d == 8'haa) ? 5 : 0;
        2: begin
          step = 0;
          cmd = d;
          if (a == 11'h555) case (d)
            8'ha0, 8'ha5, 8'h85: step = 3;
            8'h80: step = 4;
            8'h90: mode = 1;
            8'h98: mode = 2;
            8'h88: mode = 3;
            8'hf0: mode = 0;
            default: ;
          endcase
        end
        3: begin
          step = 0;
          if (cmd == 8'ha0) mem[addr_in] = dq_in;
          else if (cmd == 8'ha5 && !locked && addr_in >= 8 && addr_in < 136) sec[addr_in] = dq_in;
          else if (cmd == 8'h85 && dq_in == 16'h0000) locked = 1'b1;
          if (cmd != 8'h85) busy_cnt <= 5;
        end
        6: begin
          step = 0;
          if (d == 8'h10 && a == 11'h555) mem.delete();
          if (d == 8'h50 || d == 8'h30 || (d == 8'h10 && a == 11'h555)) busy_cnt <= 40;
        end
        default: step = 0;
      endcase
    end
  end
endmodule : flash_device_model
`default_nettype wire

// >>> sim/flash_command_sequencer_tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer_tb import flash_cmd_pkg::*;;
  logic        mclk_in = 0, rst_n_in = 0, req_valid = 0;
  logic [3:0]  req_op = 0;
  logic [18:0] req_addr = 0, addr, ra;
  logic [15:0] req_data = 0, dq_in, rd_data, dq_out, rv;
  logic        busy, ready, done, rst_n_out, ce_n, oe_n, we_n, dq_oe_n, pwe, pce;
  logic [36:0] log_q[$], exp_q[$];  // Writes as kind, address, data
  logic [15:0] mem [int], sec [int];
  int          mode, num_errors, checked;
  logic        locked = 0;
  always #5 mclk_in = ~mclk_in;
  flash_command_sequencer flash_command_sequencer_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr), .req_data_in(req_data),
    .flash_busy_in(busy), .dq_in(dq_in), .req_ready_out(ready), .done_out(done), .rd_data_out(rd_data),
    .rst_n_out(rst_n_out), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr),
    .dq_out(dq_out), .dq_oe_n_out(dq_oe_n));
  flash_device_model flash_device_model_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_out), .ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr), .dq_in(dq_out), .busy_out(busy), .dq_out(dq_in));
  // Log every write when its strobe rises
  always @(posedge mclk_in) begin
    pwe <= we_n;
    pce <= ce_n;
    if (!pwe && !pce && we_n && rst_n_in) begin
      log_q.push_back({2'd0, addr, dq_out});
      chk("write pins", 37'h2, {35'h0, oe_n, dq_oe_n});
    end
  end
  task chk(input string what, input logic [36:0] e, input logic [36:0] s);
    checked++;
    if (e !== s) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task conclude;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task px(input logic [1:0] k, input logic [18:0] a, input logic [15:0] d);
    exp_q.push_back({k, a, d});
  endtask : px
  task unl;
    px(2'd0, 19'h555, 16'h00aa);
    px(2'd0, 19'h2aa, 16'h0055);
  endtask : unl
  // One operation: expected writes, handshake, then compare writes and read data
  task run(input logic [3:0] op, input logic [18:0] a, input logic [15:0] d);
    int n;
    logic [36:0] e, s;
    exp_q.delete();
    log_q.delete();
    case (op)
      OP_PROGRAM, OP_SEC_PROG: begin
        unl();
        px(2'd0, 19'h555, op == OP_PROGRAM ? 16'h00a0 : 16'h00a5);
        px(2'd1, a, d);
      end
      OP_SECTOR, OP_BLOCK, OP_CHIP: begin
        unl();
        px(2'd0, 19'h555, 16'h0080);
        unl();
        px(op == OP_CHIP ? 2'd0 : 2'd2, op == OP_CHIP ? 19'h555 : a,
           op == OP_SECTOR ? 16'h0050 : op == OP_BLOCK ? 16'h0030 : 16'h0010);
      end
      OP_IDENT, OP_CFI, OP_SEC_READ, OP_EXIT_LONG: begin
        unl();
        px(2'd0, 19'h555, op == OP_IDENT ? 16'h0090 : op == OP_CFI ? 16'h0098 : op == OP_SEC_READ ? 16'h0088 : 16'h00f0);
      end
      OP_CFI_ONE: px(2'd0, 19'h055, 16'h0098);
      OP_SEC_LOCK: begin
        unl();
        px(2'd0, 19'h555, 16'h0085);
        px(2'd3, 19'h0, 16'h0000);
      end
      OP_EXIT_SHORT: px(2'd3, 19'h0, 16'h00f0);
      default: ;
    endcase
    @(posedge mclk_in);
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    do begin @(posedge mclk_in); n++; end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      $display("Error handshake expected done seen timeout");
      conclude();
    end else begin
      if (op == OP_READ) chk("read data", {21'h0, mode == 1 ? (a == 0 ? 16'h00c3 : 16'h7e21) :
        mode == 2 ? 16'hc000 | a[7:0] : mode == 3 ? (sec.exists(a) ? sec[a] : 16'hffff) :
        (mem.exists(a) ? mem[a] : 16'hffff)}, {21'h0, rd_data});
      if (op == OP_PROGRAM) mem[a] = d;
      if (op == OP_CHIP) mem.delete();
      if (op == OP_SEC_PROG && !locked && a >= 8 && a < 136) sec[a] = d;
      if (op == OP_SEC_LOCK) locked = 1'b1;
      if (op inside {OP_IDENT, OP_CFI, OP_CFI_ONE, OP_SEC_READ, OP_EXIT_LONG, OP_EXIT_SHORT})
        mode = op == OP_IDENT ? 1 : op == OP_SEC_READ ? 3 : op inside {OP_CFI, OP_CFI_ONE} ? 2 : 0;
      chk("write count", 37'(exp_q.size()), 37'(log_q.size()));
      foreach (exp_q[i]) begin
        e = exp_q[i];
        s = (i < log_q.size()) ? log_q[i] : '0;
        s[36:35] = e[36:35];
        if (e[36:35] == 2'd0) s[34:27] = e[34:27];
        if (e[36:35] == 2'd2) s[26:16] = e[26:16];
        if (e[36:35] == 2'd3) s[34:16] = e[34:16];
        chk("bus write", e, s);
      end
    end
  endtask : run
  initial begin
    void'($urandom(64222));
    repeat (6) @(posedge mclk_in);
    chk("reset pins", {35'h0, ce_n, rst_n_out}, 37'h2);
    rst_n_in <= 1'b1;
    run(OP_PROGRAM, 19'h40123, 16'h5aa5);
    run(OP_READ, 19'h40123, 16'h0);
    repeat (4) begin
      ra = 19'($urandom);
      rv = 16'($urandom);
      run(OP_PROGRAM, ra, rv);
      run(OP_READ, ra, 16'h0);
    end
    $display("test program done");
    run(OP_SECTOR, 19'h12800, 16'h0);
    run(OP_BLOCK, 19'h48000, 16'h0);
    run(OP_CHIP, 19'h0, 16'h0);
    run(OP_READ, 19'h40123, 16'h0);
    $display("test erase done");
    run(OP_IDENT, 19'h0, 16'h0);
    run(OP_READ, 19'h0, 16'h0);
    run(OP_READ, 19'h1, 16'h0);
    run(OP_EXIT_SHORT, 19'h3, 16'h0);
    run(OP_CFI, 19'h0, 16'h0);
    run(OP_READ, 19'h10, 16'h0);
    run(OP_EXIT_LONG, 19'h0, 16'h0);
    run(OP_CFI_ONE, 19'h0, 16'h0);
    run(OP_READ, 19'h11, 16'h0);
    run(OP_EXIT_SHORT, 19'h5, 16'h0);
    $display("test modes done");
    run(OP_SEC_READ, 19'h0, 16'h0);
    run(OP_SEC_PROG, 19'h8, 16'h1234);
    run(OP_READ, 19'h8, 16'h0);
    run(OP_SEC_LOCK, 19'h0, 16'h0);
    run(OP_SEC_PROG, 19'h9, 16'h4321);
    run(OP_CHIP, 19'h0, 16'h0);
    run(OP_READ, 19'h9, 16'h0);
    run(OP_READ, 19'h8, 16'h0);
    run(OP_EXIT_LONG, 19'h0, 16'h0);
    $display("test security done");
    @(posedge mclk_in);
    req_op <= OP_IDENT;
    req_valid <= 1'b1;
    repeat (2) @(posedge mclk_in);
    req_valid <= 1'b0;
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("reset pins", {35'h0, ce_n, rst_n_out}, 37'h2);
    rst_n_in <= 1'b1;
    mode = 0;
    run(OP_PROGRAM, 19'h00777, 16'h0f0f);
    run(OP_READ, 19'h00777, 16'h0);
    $display("test reset done");
    conclude();
  end
endmodule : flash_command_sequencer_tb
`default_nettype wire
